//--- flash_status_boot_regs.v
// protection status, boot autoread config and per-sector erase counters behind apb
// assumes protection bits and erase events come from core logic on clk_in;
// link clock and hardware reset pin are asynchronous and are synchronised here
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "flash_status_boot_regs.vh"

module flash_status_boot_regs (
  input  wire                    clk_in,
  input  wire                    rstn_in,
  // apb slave
  input  wire                    psel_in,
  input  wire                    penable_in,
  input  wire                    pwrite_in,
  input  wire [7:0]              paddr_in,
  input  wire [31:0]             pwdata_in,
  output wire                    pready_out,
  output wire [31:0]             prdata_out,
  output wire                    pslverr_out,
  // per-sector protection bits from the core
  input  wire [`SECTOR_NUM-1:0]  persistent_protection_bit_in,
  input  wire [`SECTOR_NUM-1:0]  dynamic_protection_bit_in,
  // erase events from the core
  input  wire                    erase_done_in,
  input  wire                    erase_ok_in,
  input  wire [`SECTOR_AW-1:0]   erase_sector_in,
  input  wire                    corrupt_found_in,
  input  wire [`SECTOR_AW-1:0]   corrupt_sector_in,
  // link side
  input  wire                    link_clk_in,
  input  wire                    hw_reset_n_in,
  output wire                    autoread_busy_out,
  output wire                    autoread_go_out,
  output wire [22:0]             autoread_addr_out,
  output wire                    irq_out
);

  // ==========================================================================
  // reset release and input synchronisers
  // ==========================================================================
  reg       rst_s1_ff;
  reg       rst_s2_ff;
  wire      rstn;
  reg [2:0] link_clk_ff;
  reg [2:0] hw_rst_ff;

  // reset asserts at once, releases after two edges
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  assign rstn = rst_s2_ff;

  // stage 0 feeds only stage 1; stage 2 is the edge detector history
  always @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      link_clk_ff <= 3'h0;
      hw_rst_ff   <= 3'h7;
    end else begin
      link_clk_ff <= {link_clk_ff[1:0], link_clk_in};
      hw_rst_ff   <= {hw_rst_ff[1:0], hw_reset_n_in};
    end
  end

  wire link_rise    = link_clk_ff[1] & ~link_clk_ff[2];
  wire hw_rst_held  = ~hw_rst_ff[1];
  wire hw_rst_done  = hw_rst_ff[1] & ~hw_rst_ff[2];

  // ==========================================================================
  // apb decode
  // ==========================================================================
  wire setup_rd = psel_in & ~penable_in & ~pwrite_in;
  wire acc_wr   = psel_in & penable_in & pwrite_in;
  wire wr_sel   = acc_wr & (paddr_in == `SECTOR_SELECT_OFS);
  wire wr_cfg   = acc_wr & (paddr_in == `BOOT_CONFIG_OFS);
  wire wr_irqs  = acc_wr & (paddr_in == `IRQ_STATUS_OFS);
  wire wr_mask  = acc_wr & (paddr_in == `IRQ_MASK_OFS);

  reg [31:0]           boot_config_ff;
  reg [`SECTOR_AW-1:0] sector_sel_ff;
  reg [7:0]            persistent_status_value_ff;
  reg [7:0]            dynamic_status_value_ff;
  reg [`IRQ_W-1:0]     irq_status_ff;
  reg [`IRQ_W-1:0]     irq_mask_ff;
  reg [31:0]           prdata_ff;
  reg                  pslverr_ff;

  wire [`SECTOR_AW-1:0] sel_next = pwdata_in[`SECTOR_AW-1:0];

  // ==========================================================================
  // protection lookup: a select write is the read-protect transaction
  // ==========================================================================
  always @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      sector_sel_ff              <= {`SECTOR_AW{1'b0}};
      persistent_status_value_ff <= `STATUS_OPEN;
      dynamic_status_value_ff    <= `STATUS_OPEN;
    end else if (wr_sel) begin
      sector_sel_ff              <= sel_next;
      persistent_status_value_ff <= persistent_protection_bit_in[sel_next] ?
                                    `STATUS_OPEN : `STATUS_LOCKED;
      dynamic_status_value_ff    <= dynamic_protection_bit_in[sel_next] ?
                                    `STATUS_OPEN : `STATUS_LOCKED;
    end
  end

  // ==========================================================================
  // boot autoread config
  // ==========================================================================
  // power-on restores factory values; the pin reset keeps them so boot can use them
  always @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      boot_config_ff <= `BOOT_CONFIG_RST;
    end else if (wr_cfg) begin
      boot_config_ff <= pwdata_in;
    end
  end

  wire        cfg_enable = boot_config_ff[`CFG_ENABLE_BIT];
  wire [7:0]  cfg_delay  = boot_config_ff[`CFG_DELAY_MSB:`CFG_DELAY_LSB];
  wire [22:0] cfg_addr   = boot_config_ff[`CFG_ADDR_MSB:`CFG_ADDR_LSB];

  // ==========================================================================
  // per-sector erase counters
  // ==========================================================================
  reg [22:0]            erase_count_value_ff [0:`SECTOR_NUM-1];
  reg [`SECTOR_NUM-1:0] erase_count_corrupt_flag_ff;

  wire erase_good = erase_done_in & erase_ok_in;

  genvar g;
  generate
    for (g = 0; g < `SECTOR_NUM; g = g + 1) begin : g_sector
      // sector number narrowed on purpose to the select width
      localparam [`SECTOR_AW-1:0] SEC_IDX = g;
      wire hit_erase   = erase_good & (erase_sector_in == SEC_IDX);
      wire hit_corrupt = corrupt_found_in & (corrupt_sector_in == SEC_IDX);
      // corruption wins over a same-cycle erase so the event is never lost
      always @(posedge clk_in or negedge rstn) begin
        if (!rstn) begin
          erase_count_value_ff[g]        <= 23'h00_0000;
          erase_count_corrupt_flag_ff[g] <= 1'b0;
        end else if (hit_corrupt) begin
          erase_count_value_ff[g]        <= 23'h00_0000;
          erase_count_corrupt_flag_ff[g] <= 1'b1;
        end else if (hit_erase) begin
          // saturate rather than wrap, a wrapped count would look young
          if (erase_count_value_ff[g] != `COUNT_MAX)
            erase_count_value_ff[g] <= erase_count_value_ff[g] + 23'h00_0001;
          erase_count_corrupt_flag_ff[g] <= 1'b0;
        end
      end
    end
  endgenerate

  wire [23:0] sector_erase_counter = {erase_count_corrupt_flag_ff[sector_sel_ff],
                                      erase_count_value_ff[sector_sel_ff]};

  // ==========================================================================
  // autoread sequencer
  // ==========================================================================
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_RUN  = 3'b100;

  reg [2:0]  state_ff;
  reg [2:0]  nxt_state;
  reg [7:0]  delay_cnt_ff;
  reg [7:0]  nxt_delay_cnt;
  reg        por_pending_ff;
  reg        go_ff;
  reg        nxt_go;
  reg [22:0] addr_ff;

  // one-shot power-on marker; config is factory disabled while it is set, so that path never starts
  always @(posedge clk_in or negedge rstn) begin
    if (!rstn)
      por_pending_ff <= 1'b1;
    else
      por_pending_ff <= 1'b0;
  end

  wire boot_kick = (por_pending_ff | hw_rst_done) & cfg_enable;

  // delay counts link clock rising edges seen after the kick
  always @* begin
    nxt_state     = state_ff;
    nxt_delay_cnt = delay_cnt_ff;
    nxt_go        = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (boot_kick) begin
          nxt_state     = ST_WAIT;
          nxt_delay_cnt = 8'h00;
        end
      end
      ST_WAIT: begin
        if (link_rise) begin
          if (delay_cnt_ff == cfg_delay) begin
            nxt_state = ST_RUN;
            nxt_go    = 1'b1;
          end else begin
            nxt_delay_cnt = delay_cnt_ff + 8'h01;
          end
        end
      end
      ST_RUN: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // a held pin reset aborts any boot in progress
    if (hw_rst_held) begin
      nxt_state = ST_IDLE;
      nxt_go    = 1'b0;
    end
  end

  always @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      state_ff     <= ST_IDLE;
      delay_cnt_ff <= 8'h00;
      go_ff        <= 1'b0;
      addr_ff      <= 23'h00_0000;
    end else begin
      state_ff     <= nxt_state;
      delay_cnt_ff <= nxt_delay_cnt;
      go_ff        <= nxt_go;
      if (boot_kick && state_ff == ST_IDLE)
        addr_ff <= cfg_addr;
    end
  end

  assign autoread_busy_out = (state_ff != ST_IDLE);
  assign autoread_go_out   = go_ff;
  assign autoread_addr_out = addr_ff;

  // ==========================================================================
  // interrupts: sticky, write one to clear, set beats clear
  // ==========================================================================
  wire [`IRQ_W-1:0] irq_set = {corrupt_found_in, go_ff};

  always @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      irq_status_ff <= {`IRQ_W{1'b0}};
      irq_mask_ff   <= {`IRQ_W{1'b0}};
    end else begin
      irq_status_ff <= (irq_status_ff & ~(wr_irqs ? pwdata_in[`IRQ_W-1:0] : {`IRQ_W{1'b0}}))
                       | irq_set;
      if (wr_mask)
        irq_mask_ff <= pwdata_in[`IRQ_W-1:0];
    end
  end

  assign irq_out = |(irq_status_ff & irq_mask_ff);

  // ==========================================================================
  // read data, captured in the setup cycle so prdata comes from flops
  // ==========================================================================
  reg [31:0] rd_mux;
  reg        rd_err;

  always @* begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr_in)
      `PERSIST_STATUS_OFS: rd_mux = {24'h00_0000, persistent_status_value_ff};
      `DYNAMIC_STATUS_OFS: rd_mux = {24'h00_0000, dynamic_status_value_ff};
      `BOOT_CONFIG_OFS:    rd_mux = boot_config_ff;
      `ERASE_COUNTER_OFS:  rd_mux = {8'h00, sector_erase_counter};
      `SECTOR_SELECT_OFS:  rd_mux = {{(32-`SECTOR_AW){1'b0}}, sector_sel_ff};
      `IRQ_STATUS_OFS:     rd_mux = {{(32-`IRQ_W){1'b0}}, irq_status_ff};
      `IRQ_MASK_OFS:       rd_mux = {{(32-`IRQ_W){1'b0}}, irq_mask_ff};
      default:             rd_err = 1'b1;
    endcase
  end

  // error flag for writes is decided from the address alone
  always @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (psel_in && !penable_in) begin
      prdata_ff  <= setup_rd ? rd_mux : 32'h0000_0000;
      pslverr_ff <= rd_err;
    end
  end

  // zero wait states; protection status and erase counter registers ignore writes, errors only off-map
  assign pready_out  = 1'b1;
  assign prdata_out  = prdata_ff;
  assign pslverr_out = pslverr_ff & psel_in & penable_in;

endmodule // flash_status_boot_regs

//--- flash_status_boot_regs.vh
// register map, field positions and reset values of the flash status and boot block
// assumes a 32-bit apb slave on clk_in; included by flash_status_boot_regs.v
// Function
// - persistent status reads ff when addressed sector's persistent bit is one, else 00
// - dynamic status reads ff when addressed sector's dynamic bit is one, else 00
// - enabled autoread starts by itself when hardware reset completes; power-on loads config disabled, so it never starts there
// - config bit 0 enables autoread; factory value disabled
// - config bits 31:9 give the autoread start address; factory zero
// - config bits 8:1 give initial link clock cycles before data; factory zero
// - erase counter reports 23-bit volatile erase count, zero by default
// - counter bit 23 flags a corrupted and reset count
// - corruption flag clears on next successful erase of that sector
`ifndef FLASH_STATUS_BOOT_REGS_VH
`define FLASH_STATUS_BOOT_REGS_VH

// byte offsets
`define PERSIST_STATUS_OFS 8'h00
`define DYNAMIC_STATUS_OFS 8'h04
`define BOOT_CONFIG_OFS    8'h08
`define ERASE_COUNTER_OFS  8'h0c
`define SECTOR_SELECT_OFS  8'h10
`define IRQ_STATUS_OFS     8'h14
`define IRQ_MASK_OFS       8'h18

// sector array geometry
`define SECTOR_AW          4
`define SECTOR_NUM         16

// boot config fields
`define CFG_ENABLE_BIT     0
`define CFG_DELAY_LSB      1
`define CFG_DELAY_MSB      8
`define CFG_ADDR_LSB       9
`define CFG_ADDR_MSB       31
`define BOOT_CONFIG_RST    32'h0000_0000

// status values and erase counter fields
`define STATUS_OPEN        8'hff
`define STATUS_LOCKED      8'h00
`define COUNT_MSB          22
`define CORRUPT_BIT        23
`define COUNT_MAX          23'h7f_ffff

// interrupt bits
`define IRQ_BOOT_BIT       0
`define IRQ_CORRUPT_BIT    1
`define IRQ_W              2

`endif

//--- flash_status_boot_regs_checker.sv
// checker: read values and autoread sequencing of the status block
// assumes it is bound onto flash_status_boot_regs and sees only its ports
`timescale 1ns/1ps
`include "flash_status_boot_regs.vh"
module flash_status_boot_regs_checker (
  input wire logic                   clk_in,
  input wire logic                   rstn_in,
  input wire logic                   psel_in,
  input wire logic                   penable_in,
  input wire logic                   pwrite_in,
  input wire logic [7:0]             paddr_in,
  input wire logic [31:0]            pwdata_in,
  input wire logic                   pready_out,
  input wire logic [31:0]            prdata_out,
  input wire logic                   pslverr_out,
  input wire logic [`SECTOR_NUM-1:0] persistent_protection_bit_in,
  input wire logic [`SECTOR_NUM-1:0] dynamic_protection_bit_in,
  input wire logic                   hw_reset_n_in,
  input wire logic                   autoread_busy_out,
  input wire logic                   autoread_go_out,
  input wire logic [22:0]            autoread_addr_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // ==========================================
  // shadow of what each protection status or config read should return
  logic [7:0]  pexp_ff;
  logic [7:0]  dexp_ff;
  logic [31:0] cfg_ff;
  logic [31:0] rexp_ff;
  wire         wr_acc = psel_in && penable_in && pwrite_in;
  wire         rd_acc = psel_in && penable_in && !pwrite_in;
  // read data is captured in setup, so the expectation is too
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pexp_ff <= `STATUS_OPEN;
      dexp_ff <= `STATUS_OPEN;
      cfg_ff  <= `BOOT_CONFIG_RST;
      rexp_ff <= 32'h0;
    end else begin
      if (wr_acc && paddr_in == `SECTOR_SELECT_OFS) begin
        pexp_ff <= persistent_protection_bit_in[pwdata_in[3:0]] ? `STATUS_OPEN : `STATUS_LOCKED;
        dexp_ff <= dynamic_protection_bit_in[pwdata_in[3:0]] ? `STATUS_OPEN : `STATUS_LOCKED;
      end
      if (wr_acc && paddr_in == `BOOT_CONFIG_OFS)
        cfg_ff <= pwdata_in;
      if (psel_in && !penable_in)
        rexp_ff <= (paddr_in == `PERSIST_STATUS_OFS) ? {24'h0, pexp_ff} :
                   (paddr_in == `DYNAMIC_STATUS_OFS) ? {24'h0, dexp_ff} : cfg_ff;
    end
  end
  sequence s_pin_rise;
    $rose(hw_reset_n_in) && cfg_ff[`CFG_ENABLE_BIT];
  endsequence
  sequence s_busy_soon;
    ##[2:8] autoread_busy_out;
  endsequence
  a_ready_high: assert property (pready_out) else $error("pready low");
  a_unmapped_err: assert property (psel_in && penable_in && paddr_in > `IRQ_MASK_OFS
    |-> pslverr_out && prdata_out == 32'h0) else $error("unmapped access not refused");
  a_persist_read: assert property (rd_acc && paddr_in == `PERSIST_STATUS_OFS
    |-> prdata_out == rexp_ff) else $error("persistent status wrong");
  a_dynamic_read: assert property (rd_acc && paddr_in == `DYNAMIC_STATUS_OFS
    |-> prdata_out == rexp_ff) else $error("dynamic status wrong");
  a_config_read: assert property (rd_acc && paddr_in == `BOOT_CONFIG_OFS
    |-> prdata_out == rexp_ff) else $error("boot config readback wrong");
  a_idle_in_reset: assert property (!hw_reset_n_in [*6] |-> !autoread_busy_out)
    else $error("sequencer busy in hardware reset");
  a_kick_busy: assert property (s_pin_rise |-> s_busy_soon)
    else $error("autoread not started after reset");
  a_go_addr: assert property (autoread_go_out
    |-> autoread_addr_out == cfg_ff[`CFG_ADDR_MSB:`CFG_ADDR_LSB]) else $error("start address");
  a_go_pulse: assert property (autoread_go_out |=> !autoread_go_out)
    else $error("go longer than one cycle");
  a_go_enabled: assert property (autoread_go_out
    |-> $past(autoread_busy_out) && cfg_ff[`CFG_ENABLE_BIT]) else $error("go while disabled");
endmodule // flash_status_boot_regs_checker

bind flash_status_boot_regs flash_status_boot_regs_checker i_chk (.*);

//--- link_host_model.sv
// link host model: the host's serial clock, counting its rising edges
// assumes run_in is raised by the bench only while a boot frame is wanted
`timescale 1ns/1ps
module link_host_model (
  input  wire logic       run_in,
  output logic            link_clk_out,
  output logic [7:0]      edges_out
);
  // 200 ns period off the clk_in grid; stands low between frames
  // single lane at 5 mhz, so even zero delay suits this link
  initial begin
    link_clk_out = 1'b0;
    edges_out = 8'h00;
    #37;
    forever begin
      #100;
      if (run_in) begin
        link_clk_out = ~link_clk_out;
        edges_out = edges_out + {7'h0, link_clk_out};
      end else begin
        link_clk_out = 1'b0;
        edges_out = 8'h00;
      end
    end
  end
endmodule // link_host_model

//--- tb.sv
// bench for flash_status_boot_regs: apb master, core events, link host
// assumes the checker binds itself; 40 mhz clock, 5 cycle reset
`timescale 1ns/1ps
`include "flash_status_boot_regs.vh"
module tb;
  logic        clk_in, rstn_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [7:0]  paddr_in, edges;
  logic [31:0] pwdata_in, prdata_out;
  logic        erase_done_in, erase_ok_in, corrupt_found_in, irq_out, run;
  logic [15:0] persistent_protection_bit_in, dynamic_protection_bit_in;
  logic [3:0]  erase_sector_in, corrupt_sector_in;
  logic        link_clk_in, hw_reset_n_in, autoread_busy_out, autoread_go_out;
  logic [22:0] autoread_addr_out;
  logic [7:0]  dl[3] = '{8'h00, 8'h01, 8'h05};
  logic [32:0] rq[$];
  logic [30:0] gq[$];
  string       nq[$];
  int          fails, total_checks, n;
  flash_status_boot_regs i_dut (.*);
  link_host_model i_host (.run_in(run), .link_clk_out(link_clk_in), .edges_out(edges));
  initial begin
    clk_in = 0;
    forever #12.5 clk_in = ~clk_in;
  end
  task chk(string what, logic [32:0] exp, logic [32:0] got);
    total_checks++;
    if (exp !== got) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========================================
  // apb master: request held until pready is sampled high
  task apb(logic wr, logic [7:0] a, logic [31:0] d, logic [32:0] e = 0, string nm = "");
    @(posedge clk_in);
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, wr, a, d};
    if (!wr) begin rq.push_back(e); nq.push_back(nm); end
    @(posedge clk_in) penable_in <= 1;
    n = 0;
    do begin @(posedge clk_in); n++; end while (pready_out !== 1'b1 && n < 20);
    if (n >= 20) begin fails++; close_out; end
    {psel_in, penable_in} <= 2'b00;
  endtask
  task rd(logic [7:0] a, logic [32:0] e, string nm);
    apb(0, a, 0, e, nm);
  endtask
  // one erase or corruption event from the core
  task ev(logic c, logic ok, logic [3:0] s);
    @(posedge clk_in);
    {corrupt_found_in, erase_done_in, erase_ok_in, corrupt_sector_in, erase_sector_in} <= {c, !c, ok, s, s};
    @(posedge clk_in) {corrupt_found_in, erase_done_in} <= 2'b00;
  endtask
  // program config, pulse the reset pin, run the link once busy shows
  task boot(logic [7:0] d, logic [22:0] a, logic en);
    apb(1, `BOOT_CONFIG_OFS, {a, d, en});
    rd(`BOOT_CONFIG_OFS, {1'b0, a, d, en}, "boot config");
    if (en) gq.push_back({d + 8'h01, a});
    @(posedge clk_in) hw_reset_n_in <= 0;
    repeat (6) @(posedge clk_in);
    hw_reset_n_in <= 1;
    n = 0;
    do begin @(posedge clk_in); n++; end while (autoread_busy_out !== 1'b1 && n < 20);
    if (en && n >= 20) begin fails++; close_out; end
    run <= 1;
    n = 0;
    do begin @(posedge clk_in); n++; end while (autoread_go_out !== 1'b1 && n < 600);
    if (en && n >= 600) begin fails++; close_out; end
    repeat (3) @(posedge clk_in);
    run <= 0;
  endtask
  // result watcher: oldest note against each completed read or go pulse
  always @(posedge clk_in) begin
    if (psel_in && penable_in && !pwrite_in && pready_out === 1'b1 && rq.size() > 0)
      chk(nq.pop_front(), rq.pop_front(), {pslverr_out, prdata_out});
    if (autoread_go_out === 1'b1) begin
      if (gq.size() == 0) chk("unexpected go", 1, 0);
      else chk("autoread go", gq.pop_front(), {edges, autoread_addr_out});
    end
  end
  initial begin
    {psel_in, penable_in, pwrite_in, erase_done_in, erase_ok_in, corrupt_found_in, run} = 0;
    {paddr_in, pwdata_in, erase_sector_in, corrupt_sector_in} = 0;
    {persistent_protection_bit_in, dynamic_protection_bit_in} = 32'hffff_ffff;
    hw_reset_n_in = 1'b1;
    rstn_in = 1'b0;
    fails = 0;
    total_checks = 0;
    n = $urandom(32'h28b0b907);
    repeat (5) @(posedge clk_in);
    rstn_in <= 1;
    repeat (3) @(posedge clk_in);
    rd(`PERSIST_STATUS_OFS, 33'hff, "persistent reset");
    rd(`DYNAMIC_STATUS_OFS, 33'hff, "dynamic reset");
    rd(`BOOT_CONFIG_OFS, 33'h0, "config reset");
    rd(`ERASE_COUNTER_OFS, 33'h0, "count reset");
    rd(8'h1c, 33'h1_0000_0000, "unmapped");
    $display("test reset values done");
    persistent_protection_bit_in <= (16'($urandom) & 16'hfffe) | 16'h0020;
    dynamic_protection_bit_in <= (16'($urandom) | 16'h0001) & 16'hffdf;
    for (int s = 0; s < 16; s += 5) begin
      apb(1, `SECTOR_SELECT_OFS, s);
      rd(`PERSIST_STATUS_OFS, persistent_protection_bit_in[s] ? 33'hff : 33'h0, "pstat");
      rd(`DYNAMIC_STATUS_OFS, dynamic_protection_bit_in[s] ? 33'hff : 33'h0, "dstat");
    end
    $display("test protection status done");
    foreach (dl[i]) begin
      boot(dl[i], 23'($urandom), 1'b1);
      if (i == 0) begin
        @(negedge clk_in) chk("irq masked", 0, irq_out);
        rd(`IRQ_STATUS_OFS, 33'h1, "irq status");
        apb(1, `IRQ_MASK_OFS, 1);
        @(negedge clk_in) chk("irq raised", 1, irq_out);
        apb(1, `IRQ_STATUS_OFS, 1);
        @(negedge clk_in) chk("irq cleared", 0, irq_out);
      end
    end
    boot(8'h01, 23'h0, 1'b0);
    $display("test autoread done");
    ev(0, 1, 3); ev(0, 1, 3); ev(0, 0, 3); ev(0, 1, 3); ev(1, 0, 7);
    apb(1, `SECTOR_SELECT_OFS, 3);
    rd(`ERASE_COUNTER_OFS, 33'h3, "erase count");
    apb(1, `SECTOR_SELECT_OFS, 7);
    rd(`ERASE_COUNTER_OFS, 33'h80_0000, "corrupt flag");
    ev(0, 1, 7);
    rd(`ERASE_COUNTER_OFS, 33'h1, "flag cleared");
    $display("test erase counter done");
    repeat (4) @(posedge clk_in);
    close_out;
  end
endmodule // tb
